// >>> core/pse_step_engine.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Pedometer step engine with APB registers
// Assumes: step_raw and proc_tick come from logic on pclk
// Notes:   Operation
// Operation
// - Count only with both enables set
// - Seven steps debounce after a pause
// - Step event onto pin A when routed
// - Window event if a step within period
// - Window event onto pin B when routed
// - Sixteen-bit step total readable
// - Total kept; clear bit zeroes it, overflow wraps it
// - Clear bit stays until software clears it
// - Wrap event onto pin B when routed
// - Unlatched events pulse on pins and flags
// - Latched routed events clear on status read
// - Latched but unrouted flags still pulse
// - Snapshot upper, middle time bytes per step
// - Time unit set by fine resolution bit
// - Step total offered to FIFO path
// - Twenty-four-bit timer with enable
//////////////////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps

module pse_step_engine #(
    parameter int PIN_PULSE_CYCLES   = pse_pkg::PIN_PULSE_CYC,
    parameter int STATUS_HOLD_CYCLES = pse_pkg::STATUS_HOLD_CYC,
    parameter int TS_COARSE_CYCLES   = pse_pkg::TS_COARSE_CYC,
    parameter int TS_FINE_CYCLES     = pse_pkg::TS_FINE_CYC,
    parameter int GAP_TICKS          = pse_pkg::GAP_TICKS_DEF
) (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Step algorithm
    input  wire logic                         proc_tick,
    input  wire logic                         step_raw,
    // Interrupt pins
    output logic                              interrupt_pin_a,
    output logic                              interrupt_pin_b,
    // FIFO data set
    output logic                              fifo_step_valid,
    output logic      [pse_pkg::COUNT_W-1:0]  fifo_step_data,
    output logic      [pse_pkg::TS_W-1:0]     fifo_time_data
);
    import pse_pkg::*;

    localparam int HW = $clog2(STATUS_HOLD_CYCLES + 1);
    localparam int PW = $clog2(PIN_PULSE_CYCLES + 1);
    localparam int TW = $clog2(TS_COARSE_CYCLES + TS_FINE_CYCLES + 1);
    localparam int GW = $clog2(GAP_TICKS + 1);

    //////////////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic reg_hit(input logic [31:0] a);
        logic [ADDR_W-1:0] o;
        o = a[ADDR_W-1:0];
        reg_hit = (a[31:ADDR_W] == '0) &&
                  (o == OFF_CTRL || o == OFF_ROUTE || o == OFF_WINDOW ||
                   o == OFF_FSR || o == OFF_COUNT || o == OFF_SNAP || o == OFF_TIME);
    endfunction : reg_hit

    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic [CTRL_W-1:0]   ctrl_ff;
    logic [ROUTE_W-1:0]  route_ff;
    logic [7:0]          window_ff;
    logic [COUNT_W-1:0]  count_ff;
    logic [15:0]         snap_ff;
    logic [TS_W-1:0]     ts_ff;
    logic [TW-1:0]       pre_ff;
    logic [WIN_W-1:0]    win_ticks_ff;
    logic                win_hit_ff;
    pse_db_e             db_ff;
    logic [2:0]          run_ff;
    logic [GW-1:0]       gap_ff;
    logic [EV_N-1:0]     flag_ff;
    logic [EV_N-1:0]     pin_ff;
    logic                pin_a_ff;
    logic                pin_b_ff;
    logic                fifo_vld_ff;
    logic [COUNT_W-1:0]  fifo_cnt_ff;
    logic [TS_W-1:0]     fifo_ts_ff;

    logic                setup;
    logic                done;
    logic                wr_go;
    logic                fsr_rd;
    logic [ADDR_W-1:0]   addr;
    logic                active;
    logic                step_ok;
    logic                ts_tick;
    logic [TW-1:0]       pre_lim;
    logic                det_ev;
    logic [COUNT_W:0]    sum;
    logic                wrap_ev;
    logic [WIN_W-1:0]    win_lim;
    logic                win_end;
    logic [EV_N-1:0]     ev;
    logic [EV_N-1:0]     routed;

    assign addr   = paddr[ADDR_W-1:0];
    assign setup  = psel & ~penable & ~pready_ff;
    assign done   = psel & penable & pready_ff & ~pslverr_ff;
    assign wr_go  = done & pwrite;
    assign fsr_rd = done & ~pwrite & (addr == OFF_FSR);

    //////////////////////////////////////////////////////////////////////////////////////
    // APB handshake, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~reg_hit(paddr);
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite && reg_hit(paddr)) begin
            case (addr)
                OFF_CTRL:   prdata_ff <= 32'(ctrl_ff);
                OFF_ROUTE:  prdata_ff <= 32'(route_ff);
                OFF_WINDOW: prdata_ff <= 32'(window_ff);
                OFF_FSR:    prdata_ff <= 32'(flag_ff);
                OFF_COUNT:  prdata_ff <= 32'(count_ff);
                OFF_SNAP:   prdata_ff <= 32'(snap_ff);
                OFF_TIME:   prdata_ff <= 32'(ts_ff);
                default:    prdata_ff <= '0;
            endcase
        end else if (setup) begin
            prdata_ff <= '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= CTRL_RST;
            route_ff  <= ROUTE_RST;
            window_ff <= '0;
        end else if (wr_go) begin
            case (addr)
                OFF_CTRL:   ctrl_ff   <= pwdata[CTRL_W-1:0];
                OFF_ROUTE:  route_ff  <= pwdata[ROUTE_W-1:0];
                OFF_WINDOW: window_ff <= pwdata[7:0];
                default:    ;
            endcase
        end
    end

    assign active  = ctrl_ff[CB_FUNC] & ctrl_ff[CB_PEDO];
    assign step_ok = step_raw & active;

    //////////////////////////////////////////////////////////////////////////////////////
    // Timestamp prescaler and counter
    assign pre_lim = ctrl_ff[CB_FINE] ? TW'(TS_FINE_CYCLES - 1) : TW'(TS_COARSE_CYCLES - 1);
    assign ts_tick = ctrl_ff[CB_TMR] & (pre_ff >= pre_lim);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
        end else if (!ctrl_ff[CB_TMR] || ts_tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + TW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_ff <= '0;
        end else if (wr_go && addr == OFF_TIME && pwdata[23:16] == TS_RESET_KEY) begin
            ts_ff <= '0;
        end else if (ts_tick) begin
            if (ts_ff != TS_MAX) begin
                ts_ff <= ts_ff + TS_W'(1);
            end else if (!ctrl_ff[CB_FINE]) begin
                ts_ff <= '0;
            end
        end
    end

    // Step time snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_ff <= '0;
        end else if (det_ev) begin
            snap_ff <= ts_ff[23:8];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Debounce after a pause in stepping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= '0;
        end else if (step_ok || db_ff == DB_IDLE) begin
            gap_ff <= '0;
        end else if (proc_tick && gap_ff != GW'(GAP_TICKS)) begin
            gap_ff <= gap_ff + GW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_ff  <= DB_IDLE;
            run_ff <= '0;
        end else begin
            case (db_ff)
                DB_IDLE: begin
                    if (step_ok) begin
                        db_ff  <= DB_ARM;
                        run_ff <= 3'h1;
                    end
                end
                DB_ARM: begin
                    if (step_ok && run_ff + 3'h1 == DEBOUNCE_STEPS) begin
                        db_ff <= DB_RUN;
                    end else if (step_ok) begin
                        run_ff <= run_ff + 3'h1;
                    end else if (gap_ff == GW'(GAP_TICKS)) begin
                        db_ff <= DB_IDLE;
                    end
                end
                DB_RUN: begin
                    if (!step_ok && gap_ff == GW'(GAP_TICKS)) begin
                        db_ff <= DB_IDLE;
                    end
                end
                default: db_ff <= DB_IDLE;
            endcase
        end
    end

    assign det_ev = step_ok & ((db_ff == DB_RUN) |
                    ((db_ff == DB_ARM) & (run_ff + 3'h1 == DEBOUNCE_STEPS)));

    //////////////////////////////////////////////////////////////////////////////////////
    // Step total
    assign sum = {1'b0, count_ff} +
                 ((db_ff == DB_RUN) ? (COUNT_W+1)'(1) : (COUNT_W+1)'(DEBOUNCE_STEPS));
    assign wrap_ev = det_ev & sum[COUNT_W] & ~ctrl_ff[CB_CLR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (ctrl_ff[CB_CLR]) begin
            count_ff <= '0;
        end else if (det_ev) begin
            count_ff <= sum[COUNT_W-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Step window
    assign win_lim = WIN_W'(window_ff) * WIN_W'(WIN_UNIT_TICKS);
    assign win_end = ts_tick & (window_ff != 8'h00) & (win_ticks_ff == win_lim - WIN_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_ticks_ff <= '0;
            win_hit_ff   <= 1'b0;
        end else if (window_ff == 8'h00 || !ctrl_ff[CB_TMR] || win_end) begin
            win_ticks_ff <= '0;
            win_hit_ff   <= 1'b0;
        end else begin
            if (ts_tick) begin
                win_ticks_ff <= win_ticks_ff + WIN_W'(1);
            end
            if (det_ev) begin
                win_hit_ff <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Event flags and pin requests
    assign ev[EV_STEP]     = det_ev;
    assign ev[EV_WIN]      = win_end & (win_hit_ff | det_ev);
    assign ev[EV_WRAP]     = wrap_ev;
    assign routed[EV_STEP] = route_ff[RB_STEP_A];
    assign routed[EV_WIN]  = route_ff[RB_WIN_B];
    assign routed[EV_WRAP] = route_ff[RB_WRAP_B];

    genvar gi;
    generate
        for (gi = 0; gi < EV_N; gi++) begin : g_ev
            logic          latch_m;
            logic [HW-1:0] hold_ff;
            logic [PW-1:0] pcnt_ff;

            assign latch_m = ctrl_ff[CB_LATCH] & routed[gi];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_ff[gi] <= 1'b0;
                    hold_ff     <= '0;
                end else if (ev[gi]) begin
                    flag_ff[gi] <= 1'b1;
                    hold_ff     <= HW'(STATUS_HOLD_CYCLES - 1);
                end else if (latch_m) begin
                    if (fsr_rd) begin
                        flag_ff[gi] <= 1'b0;
                    end
                end else if (flag_ff[gi]) begin
                    if (hold_ff == '0) begin
                        flag_ff[gi] <= 1'b0;
                    end else begin
                        hold_ff <= hold_ff - HW'(1);
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_ff[gi] <= 1'b0;
                    pcnt_ff    <= '0;
                end else if (ev[gi] && routed[gi]) begin
                    pin_ff[gi] <= 1'b1;
                    pcnt_ff    <= PW'(PIN_PULSE_CYCLES - 1);
                end else if (latch_m) begin
                    if (fsr_rd) begin
                        pin_ff[gi] <= 1'b0;
                    end
                end else if (pin_ff[gi]) begin
                    if (pcnt_ff == '0 || !routed[gi]) begin
                        pin_ff[gi] <= 1'b0;
                    end else begin
                        pcnt_ff <= pcnt_ff - PW'(1);
                    end
                end
            end
        end
    endgenerate

    // Pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_ff <= 1'b0;
            pin_b_ff <= 1'b0;
        end else begin
            pin_a_ff <= pin_ff[EV_STEP];
            pin_b_ff <= pin_ff[EV_WIN] | pin_ff[EV_WRAP];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // FIFO data set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_vld_ff <= 1'b0;
            fifo_cnt_ff <= '0;
            fifo_ts_ff  <= '0;
        end else begin
            fifo_vld_ff <= det_ev & ctrl_ff[CB_FIFO];
            if (det_ev && ctrl_ff[CB_FIFO]) begin
                fifo_cnt_ff <= sum[COUNT_W-1:0];
                fifo_ts_ff  <= ts_ff;
            end
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign interrupt_pin_a = pin_a_ff;
    assign interrupt_pin_b = pin_b_ff;
    assign fifo_step_valid = fifo_vld_ff;
    assign fifo_step_data  = fifo_cnt_ff;
    assign fifo_time_data  = fifo_ts_ff;

endmodule : pse_step_engine

// >>> core/pse_pkg.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and types of the pedometer step engine
// Assumes: 100 MHz pclk, 32-bit APB
// Notes:   Times in ns, cycle counts derived from them
//////////////////////////////////////////////////////////////////////////////////////////
package pse_pkg;

    // Register byte offsets
    localparam int              ADDR_W     = 5;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_ROUTE  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_WINDOW = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_FSR    = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_COUNT  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_SNAP   = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_TIME   = 5'h18;

    // Control register fields
    localparam int CB_FUNC  = 0;
    localparam int CB_PEDO  = 1;
    localparam int CB_CLR   = 2;
    localparam int CB_LATCH = 3;
    localparam int CB_TMR   = 4;
    localparam int CB_FINE  = 5;
    localparam int CB_FIFO  = 6;
    localparam int CTRL_W   = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Routing register fields
    localparam int RB_STEP_A = 0;
    localparam int RB_WIN_B  = 1;
    localparam int RB_WRAP_B = 2;
    localparam int ROUTE_W   = 3;
    localparam logic [ROUTE_W-1:0] ROUTE_RST = 3'h0;

    // Event indices, also status bit positions
    localparam int EV_STEP = 0;
    localparam int EV_WIN  = 1;
    localparam int EV_WRAP = 2;
    localparam int EV_N    = 3;

    // Step engine figures
    localparam int            COUNT_W        = 16;
    localparam int            TS_W           = 24;
    localparam int            WIN_W          = 16;
    localparam logic [2:0]    DEBOUNCE_STEPS = 3'h7;
    localparam logic [7:0]    TS_RESET_KEY   = 8'hAA;
    localparam logic [TS_W-1:0] TS_MAX       = 24'hFFFFFF;

    // Times and derived cycle counts
    localparam int CLK_NS          = 10;
    localparam int PIN_PULSE_NS    = 60000;
    localparam int STATUS_HOLD_NS  = 38461538;
    localparam int TS_COARSE_NS    = 6400000;
    localparam int TS_FINE_NS      = 25000;
    localparam int WIN_UNIT_NS     = 1638400000;
    localparam int PIN_PULSE_CYC   = PIN_PULSE_NS / CLK_NS;
    localparam int STATUS_HOLD_CYC = STATUS_HOLD_NS / CLK_NS;
    localparam int TS_COARSE_CYC   = TS_COARSE_NS / CLK_NS;
    localparam int TS_FINE_CYC     = TS_FINE_NS / CLK_NS;
    localparam int WIN_UNIT_TICKS  = WIN_UNIT_NS / TS_COARSE_NS;
    localparam int GAP_TICKS_DEF   = 52;

    // Debounce states
    typedef enum logic [2:0] {
        DB_IDLE = 3'b001,
        DB_ARM  = 3'b010,
        DB_RUN  = 3'b100
    } pse_db_e;

endpackage : pse_pkg

// >>> tb/pse_step_engine_properties.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Port checker of the pedometer step engine
// Assumes: Master keeps setup then access order
// Notes:   Shadows control and routing from APB writes
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module pse_step_engine_chk #(
    parameter int PIN_PULSE_CYCLES = 5
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Step side
    input wire logic        step_raw,
    input wire logic        interrupt_pin_a,
    input wire logic        interrupt_pin_b,
    input wire logic        fifo_step_valid
);
    import pse_pkg::*;

    logic [CTRL_W-1:0]  ctrl_ff;
    logic [ROUTE_W-1:0] route_ff;
    logic [15:0]        hi_cnt_ff;
    logic               wr_done;
    logic               bad_addr;
    logic               a_ok;

    assign wr_done  = psel && penable && pready && pwrite && !pslverr;
    assign bad_addr = (paddr > 32'h18) || (paddr[1:0] != 2'h0);
    assign a_ok     = ctrl_ff[CB_FUNC] && ctrl_ff[CB_PEDO] && route_ff[RB_STEP_A];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff  <= CTRL_RST;
            route_ff <= ROUTE_RST;
        end else if (wr_done && paddr == 32'(OFF_CTRL)) begin
            ctrl_ff <= pwdata[CTRL_W-1:0];
        end else if (wr_done && paddr == 32'(OFF_ROUTE)) begin
            route_ff <= pwdata[ROUTE_W-1:0];
        end
    end

    // High-phase length of pin A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_ff <= 16'h0;
        end else begin
            hi_cnt_ff <= interrupt_pin_a ? hi_cnt_ff + 16'h1 : 16'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_fsr_rd;
        psel && penable && pready && !pwrite && paddr == 32'(OFF_FSR);
    endsequence

    AST_APB_ANSWER: assert property (s_setup |=> pready && penable)
        else $error("No ready in access phase");
    AST_APB_STANDS: assert property (pready |=> !pready)
        else $error("Ready held too long");
    AST_UNMAPPED: assert property (pready && bad_addr |-> pslverr && prdata == 32'h0)
        else $error("Unmapped access not refused");
    AST_CTRL_READBACK: assert property (
        pready && !pwrite && paddr == 32'(OFF_CTRL) |-> prdata == 32'(ctrl_ff))
        else $error("Control readback wrong");
    AST_PIN_A_CAUSE: assert property (
        $rose(interrupt_pin_a) |-> $past(step_raw, 2) && $past(a_ok, 2))
        else $error("Pin A rose without routed step");
    AST_PIN_B_CAUSE: assert property (
        $rose(interrupt_pin_b) |-> $past(route_ff[RB_WIN_B] || route_ff[RB_WRAP_B], 2))
        else $error("Pin B rose without routing");
    AST_PIN_PULSE: assert property (
        $fell(interrupt_pin_a) && !ctrl_ff[CB_LATCH] |-> hi_cnt_ff == 16'(PIN_PULSE_CYCLES))
        else $error("Pin A pulse width wrong");
    AST_LATCH_CLEAR: assert property (
        s_fsr_rd ##0 (ctrl_ff[CB_LATCH] && route_ff[RB_STEP_A] && !step_raw)
        |-> ##2 !interrupt_pin_a)
        else $error("Pin A not cleared by status read");
    AST_FIFO_CAUSE: assert property (
        fifo_step_valid |-> $past(step_raw) && $past(ctrl_ff[CB_FIFO]))
        else $error("FIFO set without step");

endmodule : pse_step_engine_chk

bind pse_step_engine pse_step_engine_chk #(.PIN_PULSE_CYCLES(PIN_PULSE_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_raw(step_raw),
    .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b),
    .fifo_step_valid(fifo_step_valid)
);

// >>> tb/tb.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the pedometer step engine
// Assumes: Shortened counts set at the instance
// Notes:   Random step counts from a fixed seed
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module tb;
    import pse_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, proc_tick, step_raw;
    logic [31:0] paddr, pwdata, prdata, rdat, t0, d;
    logic        pready, pslverr, pin_a, pin_b, fvalid, seen_b, err;
    logic [15:0] fdata, flast, exp_cnt;
    logic [23:0] ftime, tlast;
    int          error_cnt, total_checks, cyc, n, lim;

    pse_step_engine #(.PIN_PULSE_CYCLES(5), .STATUS_HOLD_CYCLES(20),
        .TS_COARSE_CYCLES(8), .TS_FINE_CYCLES(4), .GAP_TICKS(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .proc_tick(proc_tick),
        .step_raw(step_raw), .interrupt_pin_a(pin_a), .interrupt_pin_b(pin_b),
        .fifo_step_valid(fvalid), .fifo_step_data(fdata), .fifo_time_data(ftime));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (pin_b === 1'b1) seen_b <= 1'b1;
        if (fvalid === 1'b1) {tlast, flast} <= {ftime, fdata};
        if (cyc == 95000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= 32'(a);
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk

    task automatic step(input int k);
        repeat (k) begin
            @(posedge pclk);
            step_raw <= 1'b1;
            @(posedge pclk);
            step_raw <= 1'b0;
            repeat (8) @(posedge pclk);
        end
    endtask : step

    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge pclk);
            proc_tick <= 1'b1;
            @(posedge pclk);
            proc_tick <= 1'b0;
        end
    endtask : ticks

    function automatic logic [15:0] total_after(input logic [15:0] cur, input int k,
                                                input logic run);
        return (run || k >= 7) ? cur + 16'(k) : cur;
    endfunction : total_after

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, proc_tick, step_raw, seen_b} = 6'h00;
        {paddr, pwdata, flast} = 80'h0;
        error_cnt = 0;
        total_checks = 0;
        cyc = 0;
        void'($urandom(32'h011B7CAC));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 24; a += 4)
            rd_chk(5'(a), 32'h0);
        rd_chk(5'h1C, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 5'h1C, 32'hFFFFFFFF);
        chk(32'(err), 32'h1);
        // Global enable alone counts nothing
        apb(1'b1, OFF_CTRL, 32'h01);
        apb(1'b1, OFF_ROUTE, 32'h01);
        step(8);
        rd_chk(OFF_COUNT, 32'h0);
        // Debounce then running count
        apb(1'b1, OFF_CTRL, 32'h53);
        step(6);
        rd_chk(OFF_COUNT, 32'h0);
        step(1);
        rd_chk(OFF_COUNT, 32'h7);
        n = $urandom_range(5, 1);
        step(n);
        exp_cnt = total_after(16'h7, n, 1'b1);
        rd_chk(OFF_COUNT, 32'(exp_cnt));
        chk(32'(flast), 32'(exp_cnt));
        step(1);
        exp_cnt = exp_cnt + 16'h1;
        rd_chk(OFF_FSR, 32'h1);
        repeat (25) @(posedge pclk);
        rd_chk(OFF_FSR, 32'h0);
        // Interrupted stepping needs a fresh debounce
        ticks(4);
        n = $urandom_range(6, 1);
        step(n);
        exp_cnt = total_after(exp_cnt, n, 1'b0);
        rd_chk(OFF_COUNT, 32'(exp_cnt));
        ticks(4);
        step(7);
        exp_cnt = total_after(exp_cnt, 7, 1'b0);
        rd_chk(OFF_COUNT, 32'(exp_cnt));
        apb(1'b1, OFF_CTRL, 32'h51);
        step(3);
        rd_chk(OFF_COUNT, 32'(exp_cnt));
        apb(1'b1, OFF_CTRL, 32'h57);
        rd_chk(OFF_COUNT, 32'h0);
        step(3);
        rd_chk(OFF_COUNT, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h53);
        ticks(4);
        step(7);
        rd_chk(OFF_COUNT, 32'h7);
        // Latched, routed and unrouted
        apb(1'b1, OFF_CTRL, 32'h5B);
        step(1);
        repeat (30) @(posedge pclk);
        chk(32'(pin_a), 32'h1);
        rd_chk(OFF_FSR, 32'h1);
        rd_chk(OFF_FSR, 32'h0);
        chk(32'(pin_a), 32'h0);
        apb(1'b1, OFF_ROUTE, 32'h0);
        step(1);
        rd_chk(OFF_FSR, 32'h1);
        repeat (25) @(posedge pclk);
        rd_chk(OFF_FSR, 32'h0);
        // Timer rate in both resolutions
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, OFF_CTRL, 32'h53 | 32'(f << 5));
            apb(1'b1, OFF_TIME, 32'h00AA0000);
            apb(1'b0, OFF_TIME, 32'h0);
            t0 = rdat;
            chk(32'(t0 <= 32'h3), 32'h1);
            repeat (400) @(posedge pclk);
            apb(1'b0, OFF_TIME, 32'h0);
            d = rdat - t0;
            lim = (f == 1) ? 100 : 50;
            chk(32'(d >= 32'(lim - 2) && d <= 32'(lim + 4)), 32'h1);
        end
        // Window event on pin B
        apb(1'b1, OFF_CTRL, 32'h53);
        apb(1'b1, OFF_WINDOW, 32'h1);
        apb(1'b1, OFF_ROUTE, 32'h2);
        seen_b <= 1'b0;
        step(1);
        for (int w = 0; w < 4300 && seen_b !== 1'b1; w++) @(posedge pclk);
        chk(32'(seen_b), 32'h1);
        repeat (10) @(posedge pclk);
        seen_b <= 1'b0;
        repeat (2100) @(posedge pclk);
        chk(32'(seen_b), 32'h0);
        // Snapshot lies between two timer reads
        apb(1'b0, OFF_TIME, 32'h0);
        t0 = rdat;
        step(1);
        apb(1'b0, OFF_SNAP, 32'h0);
        d = rdat;
        apb(1'b0, OFF_TIME, 32'h0);
        chk(32'(d >= 32'(t0[23:8]) && d <= 32'(rdat[23:8])), 32'h1);
        chk(32'(tlast >= t0 && tlast <= rdat), 32'h1);
        // Count wrap on pin B
        apb(1'b1, OFF_WINDOW, 32'h0);
        apb(1'b1, OFF_ROUTE, 32'h4);
        apb(1'b1, OFF_CTRL, 32'h57);
        apb(1'b1, OFF_CTRL, 32'h53);
        repeat (5) @(posedge pclk);
        seen_b <= 1'b0;
        step_raw <= 1'b1;
        repeat (65536) @(posedge pclk);
        step_raw <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(32'(seen_b), 32'h1);
        rd_chk(OFF_COUNT, 32'h0);
        stop_test();
    end

endmodule : tb
